//--- hdl/asc_pkg.sv
// Purpose: Shared constants for the serial command port and sequencer.
// Assumes: One sequence count per ref_clk cycle.
// Notes: Phase windows are fixed counts within one 2048-count cycle.
package asc_pkg;
	// Serial frame and command byte layout.
	localparam int FRAME_BITS = 8;
	localparam int CMD_SEL_BIT = 0;
	localparam int CMD0_START_BIT = 7;
	localparam int CMD0_LINE_BIT = 6;
	localparam int CMD0_SLEEP_BIT = 5;
	localparam int CMD0_ZERO_BIT = 4;
	localparam int CMD0_SEL_LOW_BIT = 2;
	localparam int CMD0_SEL_HIGH_BIT = 1;
	localparam int CMD1_OUT_LSB = 4;
	// Status byte layout.
	localparam int ST_COLLISION_BIT = 7;
	localparam int ST_DONE_BIT = 6;
	localparam int ST_INT_BIT = 5;
	localparam int ST_SLEEP_BIT = 4;
	localparam int ST_POL_BIT = 3;
	// Reset values.
	localparam logic [7:0] CMD0_RESET = 8'h00;
	localparam logic [7:0] CMD1_RESET = 8'h01;
	localparam logic [7:0] TX_RESET = 8'h00;
	// Sequence counter.
	localparam int SEQ_W = 11;
	localparam logic [10:0] SEQ_IDLE = 11'h000;
	localparam logic [10:0] SEQ_FIRST = 11'h001;
	localparam logic [10:0] SEQ_LAST = 11'h7ff;
	localparam logic [2:0] START_CLEAR_CYCLES = 3'h5;
	// Integrate window: 545 counts at 60 Hz, 655 counts at 50 Hz.
	localparam logic [10:0] INT_BEGIN = 11'h001;
	localparam logic [10:0] INT_END_60 = 11'h222;
	localparam logic [10:0] INT_END_50 = 11'h290;
	// Deintegrate windows, one per phase, each ending at its max count.
	localparam logic [10:0] DE_BEGIN [4] = '{11'h2bc, 11'h514, 11'h578, 11'h5dc};
	localparam logic [10:0] DE_END [4] = '{11'h500, 11'h564, 11'h5c8, 11'h62c};
	localparam logic [19:0] DE_STEP [4] = '{20'h00200, 20'h00040, 20'h00008, 20'h00001};
	// Results counter and hard overrange clamp of 350,440 counts.
	localparam int ACC_W = 20;
	localparam int RES_W = 19;
	localparam logic [19:0] CLAMP_POS = 20'h558e8;
	localparam logic [19:0] CLAMP_NEG = 20'haa718;
endpackage

//--- hdl/asc_top.sv
// Purpose: Serial command port, conversion sequencer and results counter.
// Assumes: Host initialises both command registers after power-up.
// Notes: Serial logic runs on sclk; everything else runs on ref_clk.
`timescale 1ns/1ps

module asc_top (
	// Oscillator clock and reset.
	input wire logic ref_clk,
	input wire logic reset_n,
	// Serial command port.
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic din,
	output logic dout,
	// Analog front end.
	input wire logic comp_zero,
	input wire logic comp_neg,
	output logic integrating,
	output logic deintegrating,
	output logic input_short,
	output logic line_50hz,
	output logic sleep_mode,
	// Conversion done and general outputs.
	output logic conv_done,
	output logic user_out_a,
	output logic user_out_b,
	output logic user_out_c,
	output logic user_out_d
);

	////////////////////////////////////////////////////////////////////////
	// Serial link on sclk.

	logic [7:0] rx_shift;
	logic [2:0] tx_index;
	logic [7:0] tx_hold;

	// Bits enter on rising edges, MSB first.
	always_ff @(posedge sclk) begin
		rx_shift <= {rx_shift[6:0], din};
	end

	// Output bit moves on falling edges; idle select rewinds to MSB.
	always_ff @(negedge sclk or posedge cs_n) begin
		if (cs_n) begin
			tx_index <= 3'h7;
		end else begin
			tx_index <= tx_index - 3'h1;
		end
	end

	// The selected byte is frozen for the whole frame, so this mux reads
	// only stable data and the first bit is ready before any clock edge.
	assign dout = tx_hold[tx_index];

	////////////////////////////////////////////////////////////////////////
	// Crossings into ref_clk.

	logic cs_meta, cs_sync, cs_prev;
	logic zero_meta, zero_sync, neg_meta, neg_sync;
	logic frame_end;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			cs_meta <= 1'b1;
			cs_sync <= 1'b1;
			cs_prev <= 1'b1;
			zero_meta <= 1'b0;
			zero_sync <= 1'b0;
			neg_meta <= 1'b0;
			neg_sync <= 1'b0;
		end else begin
			cs_meta <= cs_n;
			cs_sync <= cs_meta;
			cs_prev <= cs_sync;
			zero_meta <= comp_zero;
			zero_sync <= zero_meta;
			neg_meta <= comp_neg;
			neg_sync <= neg_meta;
		end
	end

	// The shift register holds still once select is high, so it is safe
	// to take it after the synchronised rising edge.
	assign frame_end = cs_sync && !cs_prev;

	////////////////////////////////////////////////////////////////////////
	// Command registers.

	logic [7:0] cmd0;
	logic [7:0] cmd1;
	logic start_pending;
	logic start_clear;
	logic write_start;

	assign write_start = frame_end && !rx_shift[asc_pkg::CMD_SEL_BIT]
		&& rx_shift[asc_pkg::CMD0_START_BIT];

	// Bit 0 of the latched byte picks the command register.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			cmd0 <= asc_pkg::CMD0_RESET;
			cmd1 <= asc_pkg::CMD1_RESET;
		end else if (frame_end) begin
			if (rx_shift[asc_pkg::CMD_SEL_BIT]) begin
				cmd1 <= rx_shift;
			end else begin
				cmd0 <= rx_shift;
			end
		end
	end

	// A new start write wins over the self-clear in the same cycle.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			start_pending <= 1'b0;
		end else if (write_start) begin
			start_pending <= 1'b1;
		end else if (start_clear) begin
			start_pending <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sequence counter.

	logic [10:0] seq;
	logic [2:0] clear_count;
	logic clear_run;
	logic accept;
	logic conv_end;
	logic [10:0] int_end;

	// Starts only from 0000, awake; other times the bit waits.
	assign accept = start_pending && (seq == asc_pkg::SEQ_IDLE)
		&& !clear_run && !cmd0[asc_pkg::CMD0_SLEEP_BIT];
	assign conv_end = (seq == asc_pkg::SEQ_LAST);
	assign int_end = cmd0[asc_pkg::CMD0_LINE_BIT] ? asc_pkg::INT_END_50
		: asc_pkg::INT_END_60;

	// Idle holds at 0000; the run wraps back there and stops.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			seq <= asc_pkg::SEQ_IDLE;
		end else if (accept) begin
			seq <= asc_pkg::SEQ_FIRST;
		end else if (seq != asc_pkg::SEQ_IDLE) begin
			seq <= seq + 11'h001;
		end
	end

	// The start bit is dropped five cycles after it was accepted.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			clear_count <= 3'h0;
			clear_run <= 1'b0;
			start_clear <= 1'b0;
		end else begin
			start_clear <= 1'b0;
			if (accept) begin
				clear_run <= 1'b1;
				clear_count <= 3'h1;
			end else if (clear_run) begin
				clear_count <= clear_count + 3'h1;
				if (clear_count == asc_pkg::START_CLEAR_CYCLES - 3'h1) begin
					start_clear <= 1'b1;
					clear_run <= 1'b0;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Deintegrate phases and results counter.

	logic [3:0] de_window;
	logic [3:0] de_active;
	logic [3:0] de_neg;
	logic [19:0] acc;
	logic [19:0] next_acc;
	logic [19:0] step;

	genvar ph;
	generate
		for (ph = 0; ph < 4; ph++) begin : g_phase
			assign de_window[ph] = (seq >= asc_pkg::DE_BEGIN[ph])
				&& (seq < asc_pkg::DE_END[ph]);
			// Each phase opens at a fixed count, closes at zero cross.
			always_ff @(posedge ref_clk or negedge reset_n) begin
				if (!reset_n) begin
					de_active[ph] <= 1'b0;
					de_neg[ph] <= 1'b0;
				end else if (seq == asc_pkg::DE_BEGIN[ph]) begin
					de_active[ph] <= 1'b1;
					de_neg[ph] <= neg_sync;
				end else if (zero_sync || !de_window[ph]) begin
					de_active[ph] <= 1'b0;
				end
			end
		end
	endgenerate

	// Only one phase window is open at a time.
	always_comb begin
		step = 20'h00000;
		for (int i = 0; i < 4; i++) begin
			if (de_active[i] && de_window[i]) begin
				step = de_neg[i] ? (20'h00000 - asc_pkg::DE_STEP[i])
					: asc_pkg::DE_STEP[i];
			end
		end
	end

	// Up or down by the step, clamped at the hard overrange.
	always_comb begin
		next_acc = acc + step;
		if (!next_acc[19] && (next_acc > asc_pkg::CLAMP_POS)) begin
			next_acc = asc_pkg::CLAMP_POS;
		end else if (next_acc[19] && (next_acc < asc_pkg::CLAMP_NEG)) begin
			next_acc = asc_pkg::CLAMP_NEG;
		end
	end

	// Cleared at each start; offset and input sum raw.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			acc <= 20'h00000;
		end else if (accept) begin
			acc <= 20'h00000;
		end else begin
			acc <= next_acc;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Results register and collision.

	logic [18:0] result;
	logic result_neg;
	logic collision;
	logic update_in_frame;
	logic [1:0] frame_sel;

	// Copied at each conversion end, twos complement.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			result <= 19'h00000;
			result_neg <= 1'b0;
		end else if (conv_end) begin
			result <= acc[18:0];
			result_neg <= acc[19];
		end
	end

	// Remember which register this frame is reading out.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			frame_sel <= 2'h0;
		end else if (cs_sync) begin
			frame_sel <= {cmd0[asc_pkg::CMD0_SEL_HIGH_BIT],
				cmd0[asc_pkg::CMD0_SEL_LOW_BIT]};
		end
	end

	// Update inside a frame flags at select rise.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			update_in_frame <= 1'b0;
			collision <= 1'b0;
		end else begin
			if (frame_end) begin
				update_in_frame <= 1'b0;
			end else if (conv_end && !cs_sync) begin
				update_in_frame <= 1'b1;
			end
			if (frame_end && update_in_frame) begin
				collision <= 1'b1;
			end else if (frame_end && (frame_sel == 2'h2)) begin
				collision <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output byte and pins.

	logic [7:0] next_tx;

	always_comb begin
		unique case ({cmd0[asc_pkg::CMD0_SEL_HIGH_BIT],
			cmd0[asc_pkg::CMD0_SEL_LOW_BIT]})
			2'h0: next_tx = result[10:3];
			2'h1: next_tx = result[18:11];
			2'h2: next_tx = {collision, conv_done, integrating,
				sleep_mode, result_neg, result[2:0]};
			2'h3: next_tx = 8'h00;
		endcase
	end

	// Reloaded only between frames so the link sees a stable byte.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_hold <= asc_pkg::TX_RESET;
		end else if (cs_sync) begin
			tx_hold <= next_tx;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			conv_done <= 1'b1;
			integrating <= 1'b0;
			deintegrating <= 1'b0;
		end else begin
			conv_done <= (seq == asc_pkg::SEQ_IDLE);
			integrating <= (seq >= asc_pkg::INT_BEGIN)
				&& (seq < int_end);
			deintegrating <= |(de_active & de_window);
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			sleep_mode <= 1'b0;
			input_short <= 1'b0;
			line_50hz <= 1'b0;
			user_out_a <= 1'b0;
			user_out_b <= 1'b0;
			user_out_c <= 1'b0;
			user_out_d <= 1'b0;
		end else begin
			sleep_mode <= cmd0[asc_pkg::CMD0_SLEEP_BIT];
			input_short <= cmd0[asc_pkg::CMD0_ZERO_BIT];
			line_50hz <= cmd0[asc_pkg::CMD0_LINE_BIT];
			user_out_a <= cmd1[asc_pkg::CMD1_OUT_LSB];
			user_out_b <= cmd1[asc_pkg::CMD1_OUT_LSB + 1];
			user_out_c <= cmd1[asc_pkg::CMD1_OUT_LSB + 2];
			user_out_d <= cmd1[asc_pkg::CMD1_OUT_LSB + 3];
		end
	end

endmodule

//--- sim/asc_props.sv
// Purpose: Port timing checks for the converter control block.
// Assumes: One sequence count per ref_clk cycle.
// Notes: Small counters measure phase lengths instead of long repeats.
`timescale 1ns/1ps
module asc_props (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic reset_n,
	// Watched ports.
	input wire logic cs_n,
	input wire logic comp_zero,
	input wire logic integrating,
	input wire logic deintegrating,
	input wire logic line_50hz,
	input wire logic sleep_mode,
	input wire logic conv_done,
	input wire logic user_out_a,
	input wire logic user_out_b,
	input wire logic user_out_c,
	input wire logic user_out_d
);
	logic [11:0] low_cnt;
	logic [11:0] int_cnt;
	logic [11:0] de_cnt;
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			low_cnt <= 12'h000;
			int_cnt <= 12'h000;
			de_cnt <= 12'h000;
		end else begin
			low_cnt <= conv_done ? 12'h000 : low_cnt + 12'h001;
			int_cnt <= integrating ? int_cnt + 12'h001 : 12'h000;
			de_cnt <= deintegrating ? de_cnt + 12'h001 : 12'h000;
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	chk_conv_length: assert property (
		$rose(conv_done) |-> low_cnt == 12'h7ff)
		else $error("conversion length wrong");
	chk_integ_length: assert property (
		$fell(integrating) |-> int_cnt == (line_50hz ? 12'h28f : 12'h221))
		else $error("integrate length wrong");
	chk_integ_busy: assert property (
		integrating |-> !conv_done)
		else $error("integrating while done");
	chk_done_to_integ: assert property (
		$fell(conv_done) |-> ##[0:2] integrating)
		else $error("conversion began without integrate");
	chk_phase_excl: assert property (
		!(integrating && deintegrating))
		else $error("integrate and deintegrate overlap");
	chk_deint_bound: assert property (
		deintegrating |-> de_cnt < 12'h244)
		else $error("deintegrate window too long");
	chk_zero_stops: assert property (
		comp_zero && deintegrating |-> ##[1:4] !deintegrating)
		else $error("deintegrate ignored zero crossing");
	chk_sleep_hold: assert property (
		sleep_mode && $past(sleep_mode) && conv_done |=> conv_done)
		else $error("conversion while sleeping");
	chk_pins_quiet: assert property (
		$changed({user_out_d, user_out_c, user_out_b, user_out_a})
		|-> $past(cs_n, 3))
		else $error("general outputs changed inside a frame");
endmodule
bind asc_top asc_props u_props (.ref_clk(ref_clk), .reset_n(reset_n),
	.cs_n(cs_n), .comp_zero(comp_zero), .integrating(integrating),
	.deintegrating(deintegrating),
	.line_50hz(line_50hz), .sleep_mode(sleep_mode), .conv_done(conv_done),
	.user_out_a(user_out_a), .user_out_b(user_out_b),
	.user_out_c(user_out_c), .user_out_d(user_out_d));

//--- sim/asc_host_model.sv
// Purpose: Host processor driving the serial command port.
// Assumes: Serial clock period 12 ns, running only inside frames.
// Notes: After a frame the data line shows the inverse of its last bit.
`timescale 1ns/1ps
module asc_host_model (
	// Serial port.
	output logic sclk,
	output logic cs_n,
	output logic din,
	input wire logic dout,
	// Answer for the bench.
	output logic [7:0] rx_byte,
	output logic rx_valid
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		din = 1'b1;
		rx_byte = 8'h00;
		rx_valid = 1'b0;
	end
	task automatic frame(input logic [7:0] tx, input bit chk);
		logic [7:0] rx;
		#3 cs_n = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			din = tx[i];
			#6 sclk = 1'b1;
			rx[i] = dout;
			#6 sclk = 1'b0;
		end
		#6 cs_n = 1'b1;
		din = ~din;
		rx_byte = rx;
		rx_valid = chk;
		#2 rx_valid = 1'b0;
	endtask
endmodule

//--- sim/asc_top_tb.sv
// Purpose: Self-checking bench for the serial command port and sequencer.
// Assumes: No zero crossing is reported until the last conversion.
// Notes: Read answers are queued and checked by a separate monitor.
`timescale 1ns/1ps
module asc_top_tb;
	logic ref_clk, reset_n, comp_zero, comp_neg, sclk, cs_n, din, dout;
	logic integrating, deintegrating, input_short, line_50hz, sleep_mode;
	logic conv_done, user_out_a, user_out_b, user_out_c, user_out_d;
	logic [7:0] rx_byte;
	logic rx_valid;
	logic [7:0] exp_q[$];
	int err_count, n_tests;
	asc_top u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .sclk(sclk),
		.cs_n(cs_n), .din(din), .dout(dout), .comp_zero(comp_zero),
		.comp_neg(comp_neg), .integrating(integrating),
		.deintegrating(deintegrating), .input_short(input_short),
		.line_50hz(line_50hz), .sleep_mode(sleep_mode),
		.conv_done(conv_done), .user_out_a(user_out_a),
		.user_out_b(user_out_b), .user_out_c(user_out_c),
		.user_out_d(user_out_d));
	asc_host_model u_host (.sclk(sclk), .cs_n(cs_n), .din(din),
		.dout(dout), .rx_byte(rx_byte), .rx_valid(rx_valid));
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic final_report;
		if (err_count == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// The gap after each frame leaves the command time to land.
	task automatic xfer(input logic [7:0] tx, input bit chk,
		input logic [7:0] exp);
		if (chk)
			exp_q.push_back(exp);
		u_host.frame(tx, chk);
		repeat (8) @(posedge ref_clk);
	endtask
	task automatic wait_done(input logic lvl, input int lim);
		int n;
		n = 0;
		while (conv_done !== lvl && n < lim) begin
			@(posedge ref_clk);
			n++;
		end
		if (n == lim) begin
			err_count++;
			$display("Error at %0t: done %h wanted %h", $time, conv_done, lvl);
			final_report();
		end
	endtask
	initial forever begin
		@(posedge rx_valid);
		cmp8(rx_byte, exp_q.pop_front());
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		logic [7:0] v;
		logic neg;
		int r;
		reset_n = 1'b0;
		comp_zero = 1'b0;
		comp_neg = 1'b0;
		err_count = 0;
		n_tests = 0;
		v = $urandom(7);
		repeat (6) @(posedge ref_clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
		xfer(8'h00, 0, 8'h00);
		xfer(8'h01, 0, 8'h00);
		for (int i = 0; i < 4; i++) begin
			v = $urandom();
			xfer(v | 8'h01, 0, 8'h00);
			cmp8({4'h0, user_out_d, user_out_c, user_out_b, user_out_a},
				{4'h0, v[7:4]});
		end
		xfer(8'h70, 0, 8'h00);
		cmp8({5'h00, input_short, sleep_mode, line_50hz}, 8'h07);
		xfer(8'h00, 0, 8'h00);
		cmp8({5'h00, input_short, sleep_mode, line_50hz}, 8'h00);
		for (int k = 0; k < 2; k++) begin
			neg = $urandom();
			comp_neg <= neg;
			xfer({1'b1, k[0], 6'h00}, 0, 8'h00);
			wait_done(1'b0, 50);
			wait_done(1'b1, 2100);
			// Each window counts from the cycle after it opens to its close.
			r = 0;
			for (int i = 0; i < 4; i++)
				r += (asc_pkg::DE_END[i] - asc_pkg::DE_BEGIN[i] - 1)
					* asc_pkg::DE_STEP[i];
			r = neg ? -r : r;
			xfer(8'h00, 0, 8'h00);
			xfer(8'h04, 1, r[10:3]);
			xfer(8'h02, 1, r[18:11]);
			xfer(8'h00, 1, {4'b0100, neg, r[2:0]});
		end
		// A frame held open across the conversion end must flag it.
		xfer(8'h80, 0, 8'h00);
		repeat (2038) @(posedge ref_clk);
		xfer(8'h02, 0, 8'h00);
		wait_done(1'b1, 50);
		xfer(8'h02, 1, {4'b1100, neg, r[2:0]});
		xfer(8'h06, 1, {4'b0100, neg, r[2:0]});
		xfer(8'h00, 1, 8'h00);
		// The comparator now ends every deintegrate phase early.
		comp_zero <= 1'b1;
		xfer(8'h80, 0, 8'h00);
		wait_done(1'b1, 2100);
		final_report();
	end
endmodule
